//--- tb/mfos_contact_model.sv
`default_nettype none
module mfos_contact_model (
   input wire logic [8:0] contact_closed,
   output logic [8:0] loop_closed
);
   timeunit 1ns;
   timeprecision 1ns;
   assign loop_closed = contact_closed;
endmodule : mfos_contact_model
`default_nettype wire

//--- tb/mfos_output_select_chk.sv
`default_nettype none
module mfos_output_select_chk #(
   parameter int unsigned TICK_CYCLES = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire mfos_pkg::mfos_status_type status_i,
   input wire logic [8:0] contact_closed,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic live;
   logic pristine;
   wire logic fresh = live && pristine;
   wire logic fault_ok = status_i.fault && !status_i.fault_is_undervoltage_stop;
   // Factory codes are known only until software writes
   always_ff @(posedge clk) begin
      if (srst) begin
         live <= 1'b0;
         pristine <= 1'b1;
      end else begin
         live <= 1'b1;
         if (wb_cyc_i && wb_stb_i && wb_we_i) begin
            pristine <= 1'b0;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   AST_BUS_ACK: assert property (s_req |=> s_ack)
      else $error("bus ack not a single pulse");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_RELAY_RUN: assert property (fresh |-> contact_closed[1] == $past(status_i.running))
      else $error("relay two not following run");
   AST_RELAY_FAULT: assert property (fresh |-> contact_closed[0] == $past(fault_ok))
      else $error("relay one not following fault");
   AST_RELAY_IDLE: assert property (fresh |-> !contact_closed[2])
      else $error("relay three closed");
   AST_EXT_OFF: assert property (fresh |-> contact_closed[8:3] == 6'h00)
      else $error("extension closed without card");
   AST_IRQ_OFF: assert property (fresh |-> !irq)
      else $error("interrupt with all masked");
   AST_HOLD: assert property (fresh && $past(fresh) && $past(status_i) == $past(status_i, 2)
      |-> $stable(contact_closed))
      else $error("contact moved without cause");
endmodule : mfos_output_select_chk
bind mfos_output_select mfos_output_select_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .status_i,
   .contact_closed, .irq);
`default_nettype wire

//--- tb/mfos_output_select_tb_top.sv
`default_nettype none
module mfos_output_select_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   mfos_pkg::mfos_status_type status_i = '0;
   logic [8:0] contact_closed;
   logic irq;
   logic [8:0] loop_closed;
   logic [31:0] q;
   logic [14:0] pat [5] = '{15'h0000, 15'h7fff, 15'h5555, 15'h2aaa, 15'h4000};
   int bad_count = 0;
   int n_tests = 0;
   always #50 clk = ~clk;
   mfos_output_select #(.TICK_CYCLES(4)) uut (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .status_i, .contact_closed, .irq);
   mfos_contact_model far (.contact_closed, .loop_closed);
   task automatic results;
      $display("mismatches %0d of %0d checks", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         bad_count++;
         results();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(q, e);
   endtask : rd_chk
   task automatic chk_ct(input logic [8:0] e);
      repeat (2) @(posedge clk);
      chk({23'h0, loop_closed}, {23'h0, e});
   endtask : chk_ct
   function automatic logic cond(input logic [6:0] c, input mfos_pkg::mfos_status_type s);
      case (c)
         7'h01: return s.running;
         7'h02: return s.freq_attained;
         7'h03: return s.target_frequency_one_hit;
         7'h04: return s.target_frequency_two_hit;
         7'h05: return s.freq_cmd_zero && s.running;
         7'h06: return s.freq_cmd_zero || !s.running;
         7'h07: return s.overtorque_detector_one;
         7'h08: return s.overtorque_detector_two;
         7'h09: return s.powered && !s.abnormal;
         7'h0a: return s.undervoltage_condition;
         7'h0b: return s.fault && !s.fault_is_undervoltage_stop;
         7'h0d: return s.overheat_warning;
         7'h0e: return s.soft_brake;
         7'h0f: return s.feedback_error;
         default: return 1'b0;
      endcase
   endfunction : cond
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      status_i.running <= 1'b1;
      chk_ct(9'h002);
      status_i.fault <= 1'b1;
      status_i.fault_is_undervoltage_stop <= 1'b1;
      chk_ct(9'h002);
      status_i.fault_is_undervoltage_stop <= 1'b0;
      chk_ct(9'h003);
      rd_chk(8'h00, 32'h0b);
      rd_chk(8'h08, 32'h42);
      rd_chk(8'h40, 32'h0);
      for (int c = 0; c < 16; c++) begin
         if (c == 12) continue;
         wr(8'h00, 32'(c));
         for (int p = 0; p < 5; p++) begin
            status_i <= pat[p];
            chk_ct({7'h00, pat[p][14], cond(7'(c), pat[p])});
         end
      end
      status_i <= '0;
      wr(8'h3c, 32'h2);
      rd_chk(8'h3c, 32'h2);
      wr(8'h00, 32'h0c);
      status_i.running <= 1'b1;
      repeat (8) @(posedge clk);
      chk({31'h0, loop_closed[0]}, 32'h0);
      repeat (16) @(posedge clk);
      chk({31'h0, loop_closed[0]}, 32'h1);
      status_i.running <= 1'b0;
      chk_ct(9'h000);
      wr(8'h00, 32'h0);
      wr(8'h28, 32'h1);
      chk_ct(9'h001);
      wr(8'h28, 32'h0);
      wr(8'h00, 32'h46);
      rd_chk(8'h00, 32'h0);
      bus(1'b1, 8'h00, 32'h05, 4'he);
      rd_chk(8'h00, 32'h0);
      wr(8'h00, 32'h45);
      rd_chk(8'h00, 32'h45);
      wr(8'h00, 32'h105);
      rd_chk(8'h00, 32'h45);
      status_i.running <= 1'b1;
      for (int i = 3; i < 9; i++) begin
         wr(8'(4 * i), 32'h1);
      end
      chk_ct(9'h002);
      wr(8'h24, 32'h1);
      chk_ct(9'h01a);
      wr(8'h24, 32'h2);
      chk_ct(9'h1fa);
      wr(8'h24, 32'h3);
      rd_chk(8'h24, 32'h2);
      wr(8'h24, 32'h5);
      rd_chk(8'h24, 32'h2);
      rd_chk(8'h38, 32'h00004000);
      wr(8'h34, 32'h2);
      wr(8'h30, 32'h1ff);
      status_i.running <= 1'b0;
      chk_ct(9'h000);
      rd_chk(8'h30, 32'h1fa);
      chk({31'h0, irq}, 32'h1);
      wr(8'h30, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd_chk(8'h2c, 32'h0);
      bus(1'b1, 8'h30, 32'h000001ff, 4'h2);
      rd_chk(8'h30, 32'h000000f8);
      results();
   end
endmodule : mfos_output_select_tb_top
`default_nettype wire

//--- verilog/mfos_output_select.sv
`default_nettype none
module mfos_output_select #(
   parameter int unsigned TICK_CYCLES = mfos_pkg::BRAKE_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire mfos_pkg::mfos_status_type status_i,
   output logic [mfos_pkg::NUM_TERM-1:0] contact_closed,
   output logic irq
);
   localparam int unsigned NT = mfos_pkg::NUM_TERM;

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lane_mask

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
      merge = (old & ~lane_mask(sel)) | (dat & lane_mask(sel));
   endfunction : merge

   // Register state
   logic [mfos_pkg::CODE_W-1:0] term_code [NT];
   mfos_pkg::mfos_card_type card;
   logic [NT-1:0] nc_mask;
   logic [NT-1:0] irq_stat;
   logic [NT-1:0] irq_mask;
   logic [15:0] brake_release_delay;
   logic [NT-1:0] prev_contact;

   // Brake release timing
   logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;
   logic [15:0] run_ms;
   logic tick;
   logic brake_release;

   // Bus decode
   logic req;
   logic wr_stb;
   logic [5:0] word_idx;
   logic hit_code;
   logic hit_card;
   logic hit_nc;
   logic hit_state;
   logic hit_istat;
   logic hit_imask;
   logic hit_flags;
   logic hit_delay;
   logic [31:0] rd_mux;
   logic [31:0] wr_merged;
   logic [31:0] wr_ones;
   logic [31:0] code_rd;
   logic code_ok;

   // Condition vector and terminal gating
   logic [mfos_pkg::COND_W-1:0] cond;
   logic [NT-1:0] term_en;
   logic [NT-1:0] change_evt;
   logic [NT-1:0] next_irq_stat;

   assign req = wb_cyc_i && wb_stb_i;
   // Write lands on the edge where ack is seen high
   assign wr_stb = req && wb_we_i && wb_ack_o;
   assign word_idx = wb_adr_i[7:2];
   assign hit_code = word_idx < 6'(NT);
   assign hit_card = wb_adr_i == mfos_pkg::ADR_CARD;
   assign hit_nc = wb_adr_i == mfos_pkg::ADR_NC;
   assign hit_state = wb_adr_i == mfos_pkg::ADR_STATE;
   assign hit_istat = wb_adr_i == mfos_pkg::ADR_IRQ_STAT;
   assign hit_imask = wb_adr_i == mfos_pkg::ADR_IRQ_MASK;
   assign hit_flags = wb_adr_i == mfos_pkg::ADR_FLAGS;
   assign hit_delay = wb_adr_i == mfos_pkg::ADR_DELAY;
   assign code_rd = hit_code ? {25'h0000000, term_code[word_idx[3:0]]} : 32'h00000000;
   assign wr_merged = merge(rd_mux, wb_dat_i, wb_sel_i);
   // Clear takes only written lanes; merging old status would clear the rest
   assign wr_ones = wb_dat_i & lane_mask(wb_sel_i);
   // codes above 69 are refused, old code kept
   assign code_ok = wb_sel_i[0] && (wb_dat_i[6:0] <= mfos_pkg::CODE_MAX) &&
                    (wb_dat_i[31:7] == 25'h0000000);

   // Unmapped words read as zero
   assign rd_mux = hit_code ? code_rd :
                   hit_card ? {30'h00000000, card} :
                   hit_nc ? {23'h000000, nc_mask} :
                   hit_state ? {23'h000000, contact_closed} :
                   hit_istat ? {23'h000000, irq_stat} :
                   hit_imask ? {23'h000000, irq_mask} :
                   hit_flags ? {17'h00000, status_i} :
                   hit_delay ? {16'h0000, brake_release_delay} :
                   32'h00000000;

   always_ff @(posedge clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req && !wb_ack_o;
         wb_dat_o <= (req && !wb_ack_o && !wb_we_i) ? rd_mux : 32'h00000000;
      end
   end

   generate
      for (genvar i = 0; i < NT; i++) begin : g_code
         always_ff @(posedge clk) begin
            if (srst) begin
               term_code[i] <= mfos_pkg::CODE_RESET[i];
            end else if (wr_stb && hit_code && word_idx == 6'(i) && code_ok) begin
               term_code[i] <= wb_dat_i[6:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst) begin
         card <= mfos_pkg::CARD_NONE;
         nc_mask <= '0;
         irq_mask <= '0;
         brake_release_delay <= mfos_pkg::DELAY_RESET;
      end else if (wr_stb) begin
         // Unknown card codes are refused
         if (hit_card && wb_sel_i[0] && wb_dat_i[31:2] == 30'h00000000 &&
             wb_dat_i[1:0] != 2'h3) begin
            card <= mfos_pkg::mfos_card_type'(wb_dat_i[1:0]);
         end
         if (hit_nc) begin
            nc_mask <= wr_merged[NT-1:0];
         end
         if (hit_imask) begin
            irq_mask <= wr_merged[NT-1:0];
         end
         if (hit_delay) begin
            brake_release_delay <= wr_merged[15:0];
         end
      end
   end

   // run time counted in milliseconds, saturating
   assign tick = tick_cnt == ($bits(tick_cnt))'(TICK_CYCLES - 1);

   always_ff @(posedge clk) begin
      if (srst || !status_i.running) begin
         tick_cnt <= '0;
         run_ms <= 16'h0000;
      end else begin
         tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
         if (tick && run_ms != 16'hffff) begin
            run_ms <= run_ms + 16'h0001;
         end
      end
   end

   assign brake_release = status_i.running && (run_ms > brake_release_delay);

   assign cond[mfos_pkg::C_RUN[3:0]] = status_i.running;
   assign cond[mfos_pkg::C_FREQ[3:0]] = status_i.freq_attained;
   assign cond[mfos_pkg::C_TGT1[3:0]] = status_i.target_frequency_one_hit;
   assign cond[mfos_pkg::C_TGT2[3:0]] = status_i.target_frequency_two_hit;
   assign cond[mfos_pkg::C_ZERO[3:0]] = status_i.freq_cmd_zero && status_i.running;
   assign cond[mfos_pkg::C_ZSTOP[3:0]] = status_i.freq_cmd_zero || !status_i.running;
   assign cond[mfos_pkg::C_OT1[3:0]] = status_i.overtorque_detector_one;
   assign cond[mfos_pkg::C_OT2[3:0]] = status_i.overtorque_detector_two;
   assign cond[mfos_pkg::C_READY[3:0]] = status_i.powered && !status_i.abnormal;
   assign cond[mfos_pkg::C_LV[3:0]] = status_i.undervoltage_condition;
   assign cond[mfos_pkg::C_FAULT[3:0]] = status_i.fault &&
                                         !status_i.fault_is_undervoltage_stop;
   assign cond[mfos_pkg::C_BRAKE[3:0]] = brake_release;
   assign cond[mfos_pkg::C_OH[3:0]] = status_i.overheat_warning;
   assign cond[mfos_pkg::C_SOFT[3:0]] = status_i.soft_brake;
   assign cond[mfos_pkg::C_PIDFB[3:0]] = status_i.feedback_error;
   assign cond[mfos_pkg::C_NONE[3:0]] = 1'b0;

   // Relays always act; extension terminals per fitted card
   generate
      for (genvar i = 0; i < NT; i++) begin : g_term
         if (i < mfos_pkg::NUM_RELAY) begin : g_relay
            assign term_en[i] = 1'b1;
         end else begin : g_ext
            assign term_en[i] =
               (card == mfos_pkg::CARD_TWO &&
                (i - mfos_pkg::NUM_RELAY) < mfos_pkg::CARD_TWO_OUTS) ||
               (card == mfos_pkg::CARD_SIX &&
                (i - mfos_pkg::NUM_RELAY) < mfos_pkg::CARD_SIX_OUTS);
         end

         mfos_term u_term (
            .clk(clk),
            .srst(srst),
            .cond(cond),
            .code(term_code[i]),
            .enable(term_en[i]),
            .normally_closed(nc_mask[i]),
            .contact_closed(contact_closed[i])
         );
      end
   endgenerate

   // Any contact change is an event; set wins over clear
   assign change_evt = contact_closed ^ prev_contact;
   assign next_irq_stat = change_evt |
                          (irq_stat & ~((wr_stb && hit_istat) ? wr_ones[NT-1:0] : '0));

   always_ff @(posedge clk) begin
      if (srst) begin
         prev_contact <= '0;
         irq_stat <= '0;
         irq <= 1'b0;
      end else begin
         prev_contact <= contact_closed;
         irq_stat <= next_irq_stat;
         irq <= |(next_irq_stat & irq_mask);
      end
   end
endmodule : mfos_output_select
`default_nettype wire

//--- verilog/mfos_pkg.sv
`default_nettype none
package mfos_pkg;
   localparam int unsigned NUM_RELAY = 3;
   localparam int unsigned NUM_EXT = 6;
   localparam int unsigned NUM_TERM = NUM_RELAY + NUM_EXT;
   localparam int unsigned CODE_W = 7;
   localparam int unsigned COND_W = 16;
   localparam logic [6:0] CODE_MAX = 7'h45;
   localparam logic [15:0] DELAY_RESET = 16'h0000;

   // Clock and brake release delay time base
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned BRAKE_TICK_MS = 1;
   localparam int unsigned BRAKE_TICK_CYCLES = CLK_HZ / 1000 * BRAKE_TICK_MS;

   // Byte addresses on the register bus
   localparam logic [7:0] ADR_CODE0 = 8'h00;
   localparam logic [7:0] ADR_CARD = 8'h24;
   localparam logic [7:0] ADR_NC = 8'h28;
   localparam logic [7:0] ADR_STATE = 8'h2c;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h30;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h34;
   localparam logic [7:0] ADR_FLAGS = 8'h38;
   localparam logic [7:0] ADR_DELAY = 8'h3c;

   // Reset codes: relays 11, 1, 66; extension terminals 0
   localparam logic [CODE_W-1:0] CODE_RESET [NUM_TERM] = '{
      7'h0b, 7'h01, 7'h42, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};

   // Condition codes
   localparam logic [6:0] C_NONE = 7'h00;
   localparam logic [6:0] C_RUN = 7'h01;
   localparam logic [6:0] C_FREQ = 7'h02;
   localparam logic [6:0] C_TGT1 = 7'h03;
   localparam logic [6:0] C_TGT2 = 7'h04;
   localparam logic [6:0] C_ZERO = 7'h05;
   localparam logic [6:0] C_ZSTOP = 7'h06;
   localparam logic [6:0] C_OT1 = 7'h07;
   localparam logic [6:0] C_OT2 = 7'h08;
   localparam logic [6:0] C_READY = 7'h09;
   localparam logic [6:0] C_LV = 7'h0a;
   localparam logic [6:0] C_FAULT = 7'h0b;
   localparam logic [6:0] C_BRAKE = 7'h0c;
   localparam logic [6:0] C_OH = 7'h0d;
   localparam logic [6:0] C_SOFT = 7'h0e;
   localparam logic [6:0] C_PIDFB = 7'h0f;

   typedef enum logic [1:0] {
      CARD_NONE = 2'h0,
      CARD_TWO = 2'h1,
      CARD_SIX = 2'h2
   } mfos_card_type;

   localparam int unsigned CARD_TWO_OUTS = 2;
   localparam int unsigned CARD_SIX_OUTS = 6;

   typedef struct packed {
      logic running;
      logic freq_attained;
      logic target_frequency_one_hit;
      logic target_frequency_two_hit;
      logic freq_cmd_zero;
      logic overtorque_detector_one;
      logic overtorque_detector_two;
      logic powered;
      logic abnormal;
      logic undervoltage_condition;
      logic fault;
      logic fault_is_undervoltage_stop;
      logic overheat_warning;
      logic soft_brake;
      logic feedback_error;
   } mfos_status_type;

   localparam int unsigned STATUS_W = $bits(mfos_status_type);
endpackage : mfos_pkg
`default_nettype wire

//--- verilog/mfos_term.sv
`default_nettype none
module mfos_term (
   input wire logic clk,
   input wire logic srst,
   input wire logic [mfos_pkg::COND_W-1:0] cond,
   input wire logic [mfos_pkg::CODE_W-1:0] code,
   input wire logic enable,
   input wire logic normally_closed,
   output logic contact_closed
);
   logic in_range;
   logic active;
   logic next_contact;

   // Codes past the condition table count as inactive here; the contact then shows normally_closed
   assign in_range = code < 7'(mfos_pkg::COND_W);
   assign active = in_range && enable && cond[code[3:0]];
   assign next_contact = active ^ normally_closed;

   always_ff @(posedge clk) begin
      if (srst) begin
         contact_closed <= 1'b0;
      end else begin
         contact_closed <= next_contact;
      end
   end
endmodule : mfos_term
`default_nettype wire
